// file: rtl/port_bandwidth_limit_config.sv
// Operation
// R01 - Register 0x31 holds rx threshold low nibbles, port n at bits 4n+3:4n.
// R02 - Register 0x32 holds tx low nibbles ports 1,0 and rx ports 5,4.
// R03 - Transmit limit is threshold fields highest first, then six zeros, in kbit/s.
// R04 - Receive limit is threshold fields highest first, then six zeros, in kbit/s.
// R05 - Tx enables: ports 5,4,3 bits 11,10,9; ports 2,1,0 bits 5,3,1.
// R06 - Rx enables: ports 5,4,3 bits 8,7,6; ports 2,1,0 bits 4,2,0.
// R07 - Enable register bit 12 selects the new bandwidth control scheme.
// R08 - Enable register bit 14 set disables the carrier-sense length check.
// R09 - Enable register bit 15 set inverts the port 4 PCS clock.
// R10 - Threshold bits 10:4 come from extended registers; thresholds are eleven bits.
// R11 - Enabled direction is held at or below its limit; disabled means no limiting.
`timescale 1ns/100ps
module port_bandwidth_limit_config #(
   parameter int PORTS = bw_limit_pkg::PORTS,
   parameter int RATE_W = bw_limit_pkg::RATE_W,
   parameter int THR_HI_W = bw_limit_pkg::THR_HI_W
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [PORTS*THR_HI_W-1:0] ext_rx_thr_hi,
   input wire logic [PORTS*THR_HI_W-1:0] ext_tx_thr_hi,
   input wire logic [(PORTS-2)*bw_limit_pkg::NIBBLE_W-1:0] ext_tx_thr_low,
   input wire logic [PORTS-1:0] rx_byte_pass,
   input wire logic [PORTS-1:0] tx_byte_pass,
   output logic [PORTS*RATE_W-1:0] rx_rate_limit,
   output logic [PORTS*RATE_W-1:0] tx_rate_limit,
   output logic [PORTS-1:0] rx_limit_enable,
   output logic [PORTS-1:0] tx_limit_enable,
   output logic new_rate_scheme_enable,
   output logic carrier_length_check_disable,
   output logic port4_pcs_clock_invert,
   output logic [PORTS-1:0] rx_allow,
   output logic [PORTS-1:0] tx_allow
);

   localparam int NW = bw_limit_pkg::NIBBLE_W;

   // Register selected by an offset; every other offset selects none
   typedef enum logic [1:0] {
      SEL_NONE = 2'h0,
      SEL_RX_LOW = 2'h1,
      SEL_MIX_LOW = 2'h2,
      SEL_ENABLE = 2'h3
   } reg_sel_t;

   logic [15:0] rx_thr_low_reg;
   logic [15:0] mix_thr_low_reg;
   logic [15:0] limit_en_reg;
   logic [PORTS*NW-1:0] rx_low;
   logic [PORTS*NW-1:0] tx_low;
   logic [PORTS-1:0] rx_en;
   logic [PORTS-1:0] tx_en;

   // Build a rate from an eleven-bit threshold with six zero bits below
   function automatic logic [RATE_W-1:0] make_rate(
      input logic [THR_HI_W-1:0] hi,
      input logic [NW-1:0] lo
   );
      make_rate = {hi, lo, {bw_limit_pkg::RATE_ZERO_W{1'b0}}};
   endfunction : make_rate

   // One decode for writes and reads, so the two can never disagree on the map
   function automatic reg_sel_t reg_sel(input logic [7:0] addr);
      case (addr)
         bw_limit_pkg::RX_THR_LOW_OFS: reg_sel = SEL_RX_LOW;
         bw_limit_pkg::MIX_THR_LOW_OFS: reg_sel = SEL_MIX_LOW;
         bw_limit_pkg::LIMIT_EN_OFS: reg_sel = SEL_ENABLE;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction : reg_sel

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Receive nibbles of ports 0 to 3; writes to unmapped offsets fall through
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_thr_low_reg <= bw_limit_pkg::RX_THR_LOW_RST;
      end else if (reg_wr && (reg_sel(reg_addr) == SEL_RX_LOW)) begin
         rx_thr_low_reg <= reg_wdata; // R01
      end
   end

   // Transmit nibbles of ports 1 and 0, receive nibbles of ports 5 and 4
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         mix_thr_low_reg <= bw_limit_pkg::MIX_THR_LOW_RST;
      end else if (reg_wr && (reg_sel(reg_addr) == SEL_MIX_LOW)) begin
         mix_thr_low_reg <= reg_wdata; // R02
      end
   end

   // Enables and global bits; reserved bit 13 is kept as plain storage
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         limit_en_reg <= bw_limit_pkg::LIMIT_EN_RST;
      end else if (reg_wr && (reg_sel(reg_addr) == SEL_ENABLE)) begin
         limit_en_reg <= reg_wdata; // R05 R06 R07 R08 R09
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   // Data is held until the next read; unmapped offsets answer zero
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_sel(reg_addr))
            SEL_RX_LOW: reg_rdata <= rx_thr_low_reg;
            SEL_MIX_LOW: reg_rdata <= mix_thr_low_reg;
            SEL_ENABLE: reg_rdata <= limit_en_reg;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   // Receive nibbles: ports 0 to 3 from one register, ports 4 and 5 from the other
   always_comb begin
      rx_low = '0;
      rx_low[4*NW-1:0] = rx_thr_low_reg; // R01
      rx_low[4*NW +: NW] = mix_thr_low_reg[bw_limit_pkg::MIX_RX_P4_LSB +: NW]; // R02
      rx_low[5*NW +: NW] = mix_thr_low_reg[bw_limit_pkg::MIX_RX_P5_LSB +: NW]; // R02
   end

   // Transmit nibbles: ports 0 and 1 here, ports 2 to 5 kept in extended space
   always_comb begin
      tx_low = '0;
      tx_low[0 +: NW] = mix_thr_low_reg[bw_limit_pkg::MIX_TX_P0_LSB +: NW]; // R02
      tx_low[NW +: NW] = mix_thr_low_reg[bw_limit_pkg::MIX_TX_P1_LSB +: NW]; // R02
      tx_low[PORTS*NW-1:2*NW] = ext_tx_thr_low; // R10
   end

   // Enable bits are interleaved in the register; gather them per port
   always_comb begin
      rx_en = '0;
      tx_en = '0;
      for (int p = 0; p < PORTS; p++) begin
         rx_en[p] = limit_en_reg[bw_limit_pkg::RX_EN_POS[p]]; // R06
         tx_en[p] = limit_en_reg[bw_limit_pkg::TX_EN_POS[p]]; // R05
      end
   end

   // ----------------------------------------
   // Registered configuration outputs
   // ----------------------------------------
   // Rates; a one-cycle lag after a write keeps every output on a flop
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_rate_limit <= '0;
         tx_rate_limit <= '0;
      end else begin
         for (int p = 0; p < PORTS; p++) begin
            rx_rate_limit[p*RATE_W +: RATE_W] <=
               make_rate(ext_rx_thr_hi[p*THR_HI_W +: THR_HI_W], rx_low[p*NW +: NW]); // R04 R10
            tx_rate_limit[p*RATE_W +: RATE_W] <=
               make_rate(ext_tx_thr_hi[p*THR_HI_W +: THR_HI_W], tx_low[p*NW +: NW]); // R03 R10
         end
      end
   end

   // Per-port enables, same lag as the rates so both change together
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_limit_enable <= '0;
         tx_limit_enable <= '0;
      end else begin
         rx_limit_enable <= rx_en; // R06
         tx_limit_enable <= tx_en; // R05
      end
   end

   // Global control bits
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         new_rate_scheme_enable <= 1'b0;
         carrier_length_check_disable <= 1'b0;
         port4_pcs_clock_invert <= 1'b0;
      end else begin
         new_rate_scheme_enable <= limit_en_reg[bw_limit_pkg::EN_NEW_SCHEME_BIT]; // R07
         carrier_length_check_disable <= limit_en_reg[bw_limit_pkg::EN_CRS_CHECK_OFF_BIT]; // R08
         port4_pcs_clock_invert <= limit_en_reg[bw_limit_pkg::EN_PCS_CLK_INV_BIT]; // R09
      end
   end

   // ----------------------------------------
   // Rate meters
   // ----------------------------------------
   // One meter per port and direction, fed from the registered limits
   // Debt has no floor: bytes forced through while blocked keep deepening it,
   // and a long enough run of them would wrap the credit counter
   for (genvar g = 0; g < PORTS; g++) begin : g_meter
      rate_meter #(
         .RATE_W(RATE_W)
      ) u_rx_meter (
         .mclk(mclk),
         .rstn(rstn),
         .enable(rx_limit_enable[g]),
         .rate_kbps(rx_rate_limit[g*RATE_W +: RATE_W]),
         .byte_pass(rx_byte_pass[g]),
         .allow(rx_allow[g])
      );
      rate_meter #(
         .RATE_W(RATE_W)
      ) u_tx_meter (
         .mclk(mclk),
         .rstn(rstn),
         .enable(tx_limit_enable[g]),
         .rate_kbps(tx_rate_limit[g*RATE_W +: RATE_W]),
         .byte_pass(tx_byte_pass[g]),
         .allow(tx_allow[g])
      );
   end

endmodule : port_bandwidth_limit_config

// file: rtl/bw_limit_pkg.sv
package bw_limit_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] RX_THR_LOW_OFS = 8'h31;
   localparam logic [7:0] MIX_THR_LOW_OFS = 8'h32;
   localparam logic [7:0] LIMIT_EN_OFS = 8'h33;
   localparam logic [15:0] RX_THR_LOW_RST = 16'h0000;
   localparam logic [15:0] MIX_THR_LOW_RST = 16'h0000;
   localparam logic [15:0] LIMIT_EN_RST = 16'h0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PORTS = 6;
   localparam int NIBBLE_W = 4;
   localparam int THR_HI_W = 7;
   localparam int THR_W = 11;
   localparam int RATE_ZERO_W = 6;
   localparam int RATE_W = THR_W + RATE_ZERO_W;
   localparam int MIX_RX_P4_LSB = 0;
   localparam int MIX_RX_P5_LSB = 4;
   localparam int MIX_TX_P0_LSB = 8;
   localparam int MIX_TX_P1_LSB = 12;
   localparam int EN_PCS_CLK_INV_BIT = 15;
   localparam int EN_CRS_CHECK_OFF_BIT = 14;
   localparam int EN_NEW_SCHEME_BIT = 12;
   localparam int TX_EN_POS [PORTS] = '{1, 3, 5, 9, 10, 11};
   localparam int RX_EN_POS [PORTS] = '{0, 2, 4, 6, 7, 8};

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int KILO = 1000;
   localparam int BITS_PER_BYTE = 8;
   // Credit units per bit: rate in kbit/s is added once per clock
   localparam int BIT_COST = CLK_HZ / KILO;
   localparam int BYTE_COST = BITS_PER_BYTE * BIT_COST;
   localparam int CREDIT_W = 28;

   typedef enum logic [0:0] {
      METER_IDLE = 1'b0,
      METER_RUN = 1'b1
   } meter_state_t;

endpackage : bw_limit_pkg

// file: rtl/rate_meter.sv
`timescale 1ns/100ps
module rate_meter #(
   parameter int RATE_W = bw_limit_pkg::RATE_W,
   parameter int CREDIT_W = bw_limit_pkg::CREDIT_W,
   parameter int BURST_CREDIT = 4 * bw_limit_pkg::BYTE_COST * 64
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic [RATE_W-1:0] rate_kbps,
   input wire logic byte_pass,
   output logic allow
);

   localparam logic signed [CREDIT_W-1:0] CAP = CREDIT_W'(BURST_CREDIT);
   localparam logic signed [CREDIT_W-1:0] COST = CREDIT_W'(bw_limit_pkg::BYTE_COST);

   bw_limit_pkg::meter_state_t state_reg;
   logic signed [CREDIT_W-1:0] credit_reg;
   logic signed [CREDIT_W-1:0] credit_next;

   // ----------------------------------------
   // Credit bucket
   // ----------------------------------------
   // Refill by the rate each clock, drain per byte; capped to bound bursts
   always_comb begin
      credit_next = credit_reg;
      if (credit_reg < CAP) begin
         credit_next = credit_next + CREDIT_W'(rate_kbps);
      end
      if (byte_pass) begin
         credit_next = credit_next - COST;
      end
   end

   // Meter runs only while limiting is on; off clears any debt
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_reg <= bw_limit_pkg::METER_IDLE;
         credit_reg <= '0;
      end else begin
         case (state_reg)
            bw_limit_pkg::METER_IDLE: begin
               credit_reg <= '0;
               if (enable) begin
                  state_reg <= bw_limit_pkg::METER_RUN;
               end
            end
            bw_limit_pkg::METER_RUN: begin
               credit_reg <= credit_next; // R11
               if (!enable) begin
                  state_reg <= bw_limit_pkg::METER_IDLE;
               end
            end
            default: begin
               state_reg <= bw_limit_pkg::METER_IDLE;
               credit_reg <= '0;
            end
         endcase
      end
   end

   // Traffic may pass unless the bucket is in debt while limiting
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         allow <= 1'b1;
      end else begin
         allow <= !enable || (credit_next >= 0); // R11
      end
   end

endmodule : rate_meter

// file: verif/bw_limit_assertions.sv
`timescale 1ns/100ps
module bw_limit_checker #(
   parameter int PORTS = 6,
   parameter int RATE_W = 17,
   parameter int THR_HI_W = 7
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic [PORTS*THR_HI_W-1:0] ext_tx_thr_hi,
   input wire logic [(PORTS-2)*4-1:0] ext_tx_thr_low,
   input wire logic [PORTS*RATE_W-1:0] tx_rate_limit,
   input wire logic [PORTS-1:0] rx_limit_enable,
   input wire logic [PORTS-1:0] tx_limit_enable,
   input wire logic new_rate_scheme_enable,
   input wire logic carrier_length_check_disable,
   input wire logic port4_pcs_clock_invert,
   input wire logic [PORTS-1:0] tx_allow
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic w33;
   logic [15:0] d1, d2, d3;
   // Write data delayed to line up with the two-edge enable path
   assign w33 = reg_wr && reg_addr == 8'h33;
   always_ff @(posedge mclk) begin
      d1 <= reg_wdata;
      d2 <= d1;
      d3 <= d2;
   end
   property p_tx_en; w33 ##1 !w33 [*2] |=> tx_limit_enable == {d3[11], d3[10], d3[9], d3[5], d3[3], d3[1]}; endproperty
   property p_rx_en; w33 ##1 !w33 [*2] |=> rx_limit_enable == {d3[8], d3[7], d3[6], d3[4], d3[2], d3[0]}; endproperty
   property p_scheme; w33 ##1 !w33 [*2] |=> new_rate_scheme_enable == d3[12]; endproperty
   property p_crs; w33 ##1 !w33 [*2] |=> carrier_length_check_disable == d3[14]; endproperty
   property p_pcs; w33 ##1 !w33 [*2] |=> port4_pcs_clock_invert == d3[15]; endproperty
   property p_unmapped; reg_rd && !(reg_addr inside {8'h31, 8'h32, 8'h33}) |=> reg_rdata == 16'h0000; endproperty
   // Port 2 transmit limit comes wholly from the extended inputs
   property p_tx_rate;
      ($stable(ext_tx_thr_hi) && $stable(ext_tx_thr_low)) [*3] |->
         tx_rate_limit[50:34] == {ext_tx_thr_hi[20:14], ext_tx_thr_low[3:0], 6'h00};
   endproperty
   property p_allow; !tx_limit_enable[0] [*2] |=> tx_allow[0]; endproperty
   a_tx_en: assert property (p_tx_en) else $error("tx enable map wrong");
   a_rx_en: assert property (p_rx_en) else $error("rx enable map wrong");
   a_scheme: assert property (p_scheme) else $error("scheme bit wrong");
   a_crs: assert property (p_crs) else $error("crs check bit wrong");
   a_pcs: assert property (p_pcs) else $error("pcs invert bit wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_tx_rate: assert property (p_tx_rate) else $error("port 2 tx rate wrong");
   a_allow: assert property (p_allow) else $error("disabled port blocked");
   cover property (w33);
   cover property (tx_limit_enable[0] && !tx_allow[0]);
   cover property (reg_rd && reg_addr == 8'h30);
endmodule : bw_limit_checker
bind port_bandwidth_limit_config bw_limit_checker #(.PORTS(PORTS), .RATE_W(RATE_W), .THR_HI_W(THR_HI_W)) chk_i (
   .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .ext_tx_thr_hi(ext_tx_thr_hi), .ext_tx_thr_low(ext_tx_thr_low),
   .tx_rate_limit(tx_rate_limit), .rx_limit_enable(rx_limit_enable), .tx_limit_enable(tx_limit_enable),
   .new_rate_scheme_enable(new_rate_scheme_enable), .carrier_length_check_disable(carrier_length_check_disable),
   .port4_pcs_clock_invert(port4_pcs_clock_invert), .tx_allow(tx_allow));

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic mclk, rstn, reg_wr, reg_rd, scheme, crs_off, pcs_inv;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, ext_tl;
   logic [41:0] ext_rx, ext_tx;
   logic [5:0] rx_bp, tx_bp, rx_en, tx_en, rx_al, tx_al;
   logic [101:0] rx_rl, tx_rl;
   logic [31:0] seed = 32'h52b1;
   logic [15:0] sh [3];
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   port_bandwidth_limit_config dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_rx_thr_hi(ext_rx),
      .ext_tx_thr_hi(ext_tx), .ext_tx_thr_low(ext_tl), .rx_byte_pass(rx_bp), .tx_byte_pass(tx_bp),
      .rx_rate_limit(rx_rl), .tx_rate_limit(tx_rl), .rx_limit_enable(rx_en), .tx_limit_enable(tx_en),
      .new_rate_scheme_enable(scheme), .carrier_length_check_disable(crs_off),
      .port4_pcs_clock_invert(pcs_inv), .rx_allow(rx_al), .tx_allow(tx_al));
   // Clock and hang guard
   initial begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end
   function logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : nxt
   // Expected limit: extended high bits, low nibble, six zeros
   function logic [16:0] rate(int p, bit tx);
      logic [3:0] n;
      if (tx) n = (p < 2) ? sh[1][8+4*p+:4] : ext_tl[4*(p-2)+:4];
      else n = (p < 4) ? sh[0][4*p+:4] : sh[1][4*(p-4)+:4];
      return {tx ? ext_tx[7*p+:7] : ext_rx[7*p+:7], n, 6'h00};
   endfunction : rate
   function logic [5:0] ens(bit tx);
      int tp [6] = '{1, 3, 5, 9, 10, 11};
      int rp [6] = '{0, 2, 4, 6, 7, 8};
      for (int p = 0; p < 6; p++) ens[p] = sh[2][tx ? tp[p] : rp[p]];
   endfunction : ens
   task step(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Strobes are lowered a full cycle before the next access
   task wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      step(1);
      reg_wr = 0;
      if (a >= 8'h31 && a <= 8'h33) sh[a-8'h31] = d;
      step(1);
   endtask : wr
   task rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr = a;
      reg_rd = 1;
      step(1);
      reg_rd = 0;
      chk("rdata", reg_rdata, e);
      step(1);
      chk("rdata_hold", reg_rdata, e);
   endtask : rd
   task check_outs;
      step(3);
      for (int p = 0; p < 6; p++) begin
         chk("rx_rate", rx_rl[17*p+:17], rate(p, 0));
         chk("tx_rate", tx_rl[17*p+:17], rate(p, 1));
      end
      chk("rx_en", rx_en, ens(0));
      chk("tx_en", tx_en, ens(1));
      chk("globals", {pcs_inv, crs_off, scheme}, {sh[2][15], sh[2][14], sh[2][12]});
   endtask : check_outs
   task final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   // Main sequence: reset values, map, random register and extended values, metering
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, rx_bp, tx_bp} = '0;
      {ext_rx, ext_tx, ext_tl} = '0;
      sh = '{16'h0000, 16'h0000, 16'h0000};
      repeat (4) @(posedge mclk);
      #1 rstn = 1;
      step(1);
      for (int a = 0; a < 3; a++) rd(8'h31 + 8'(a), 16'h0000);
      check_outs();
      chk("allow", {rx_al, tx_al}, 12'hfff);
      wr(8'h30, 16'hffff);
      rd(8'h30, 16'h0000);
      rd(8'h31, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         ext_rx = (i == 0) ? '1 : 42'({nxt(), nxt()});
         ext_tx = (i == 0) ? '1 : 42'({nxt(), nxt()});
         ext_tl = (i == 0) ? '1 : 16'(nxt());
         for (int a = 0; a < 3; a++) wr(8'h31 + 8'(a), (i == 0) ? 16'hffff : (i == 1) ? 16'h8001 : 16'(nxt()));
         for (int a = 0; a < 3; a++) rd(8'h31 + 8'(a), sh[a]);
         check_outs();
      end
      // One byte at 64 kbit/s costs about 3125 cycles of refill
      wr(8'h33, 16'h0000);
      ext_tx = '0;
      wr(8'h32, 16'h0100);
      wr(8'h33, 16'h0002);
      step(3);
      chk("tx_allow0", tx_al[0], 1'b1);
      tx_bp = 6'h01;
      rx_bp = 6'h02;
      step(1);
      {tx_bp, rx_bp} = '0;
      step(1);
      chk("allow_hit", {rx_al, tx_al}, 12'hffe);
      step(3098);
      chk("tx_allow0", tx_al[0], 1'b0);
      step(50);
      chk("tx_allow0", tx_al[0], 1'b1);
      // Mid-run reset with the meter in debt: everything returns to reset values
      tx_bp = 6'h01;
      step(1);
      tx_bp = 6'h00;
      rstn = 0;
      step(2);
      rstn = 1;
      sh = '{16'h0000, 16'h0000, 16'h0000};
      step(1);
      chk("allow_rst", {rx_al, tx_al}, 12'hfff);
      for (int a = 0; a < 3; a++) rd(8'h31 + 8'(a), 16'h0000);
      check_outs();
      final_report();
   end
endmodule : testbench
